// file: verilog/simple_i2c_error_recovery.sv
// Simplified I2C master channel with error flagging and stop/start recovery
// How it works
// (R1) Buffer read clears full flag, reopens reception
// (R2) Software reads data buffer first
// (R3) Software then reads status, keeps value
// (R4) Clear write clears only its 1 bits
// (R5) Flag overrun and missing acknowledge
// (R6) Stop trigger clears enable, halts channel
// (R7) Start trigger sets enable, resumes channel
// (R8) Software clears flags, stops, releases bus
// (R9) Software may instead repeat start
// (R10) Wait four clocks before prescaler write
// (R11) Only pairs 02, 03, 10, 11 work
// (R12) Error flags sticky until cleared
`timescale 1ns/1ns
`default_nettype none
`include "i2c_err_defs.svh"
module simple_i2c_error_recovery (
  input  wire logic       i_clock,          // 125 MHz clock
  input  wire logic       i_nrst,           // Async reset, active low
  input  wire logic [2:0] i_pair,           // {unit,channel} of this channel
  input  wire logic       i_buf_read,       // Pulse: data buffer read
  input  wire logic       i_clear_write,    // Pulse: flag clear write
  input  wire logic [1:0] i_clear_value,    // Value written to clear
  input  wire logic       i_stop_trigger,   // Pulse: stop trigger
  input  wire logic       i_start_trigger,  // Pulse: start trigger
  input  wire logic       i_periph_enable,  // Peripheral enable level
  input  wire logic       i_scl,            // Bus clock from the line
  input  wire logic       i_sda,            // Bus data from the line
  output logic [7:0]      o_data,           // Receive data buffer
  output logic            o_buffer_full,    // Buffer full flag
  output logic [1:0]      o_status,         // Error flags {parity,overrun}
  output logic            o_enable_status,  // Channel enable status
  output logic            o_prescaler_ok    // Prescaler may be written
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers, three stages
  logic [2:0] scl_sync_reg;  // Bus clock stages
  logic [2:0] sda_sync_reg;  // Bus data stages
  logic       scl_reg;       // Filtered bus clock
  // Shift the pins in
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
    end
  end
  // Rising edge once stages two and three agree
  wire scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_reg;
  wire sda_bit  = sda_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Pair check
  function automatic logic pair_ok(input logic [2:0] p);
    pair_ok = (p == `PAIR_02) || (p == `PAIR_03) || (p == `PAIR_10) || (p == `PAIR_11);
  endfunction
  // (R11) Pair gating of operation
  wire chan_legal = pair_ok(i_pair);

  ////////////////////////////////////////////////////////////////////////////
  // Channel enable and bit engine
  i2c_err_pkg::bit_state_t state_reg;     // Engine state
  logic [2:0]              bit_cnt_reg;   // Bit index in frame
  logic [7:0]              shift_reg;     // Incoming byte
  logic                    en_reg;        // Channel enable status
  logic [7:0]              data_reg;      // Receive buffer
  logic                    full_reg;      // Buffer full
  i2c_err_pkg::err_flags_t flags_reg;     // Sticky error flags
  logic [2:0]              wait_cnt_reg;  // Clocks since peripheral enable
  logic                    prescaler_ok_reg; // Prescaler may be written
  wire running   = en_reg && chan_legal;
  wire byte_done = running && scl_rise && (state_reg == i2c_err_pkg::ST_DATA)
                   && (bit_cnt_reg == `BIT_LAST);
  wire ack_seen  = running && scl_rise && (state_reg == i2c_err_pkg::ST_ACK);
  // (R5) Overrun when a byte lands on a full buffer
  wire set_ovr   = byte_done && full_reg && !i_buf_read;
  // (R5) No acknowledge shows as parity error
  wire set_par   = ack_seen && sda_bit;

  // (R6) (R7) Stop wins over start in the same cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      en_reg <= 1'b0;
    end else if (i_stop_trigger) begin
      en_reg <= 1'b0;
    end else if (i_start_trigger && chan_legal) begin
      en_reg <= 1'b1;
    end
  end

  // Bit engine leaves idle on the next clock, then steps on bus clock rising edges
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg   <= i2c_err_pkg::ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= `DATA_RST;
    end else if (!running) begin
      state_reg   <= i2c_err_pkg::ST_IDLE;
      bit_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        i2c_err_pkg::ST_IDLE: begin
          state_reg <= i2c_err_pkg::ST_DATA;
        end
        i2c_err_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_bit};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `BIT_LAST) begin
              state_reg <= i2c_err_pkg::ST_ACK;
            end
          end
        end
        i2c_err_pkg::ST_ACK: begin
          if (scl_rise) begin
            state_reg <= i2c_err_pkg::ST_DATA;
          end
        end
        default: begin
          state_reg <= i2c_err_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer
  wire [7:0] new_byte = {shift_reg[6:0], sda_bit};
  // (R1) Read empties buffer; a byte arriving keeps it full
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      data_reg <= `DATA_RST;
      full_reg <= 1'b0;
    end else if (byte_done && (!full_reg || i_buf_read)) begin
      data_reg <= new_byte;
      full_reg <= 1'b1;
    end else if (i_buf_read) begin
      full_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags
  wire clr_ovr = i_clear_write && i_clear_value[`OVR_BIT];
  wire clr_par = i_clear_write && i_clear_value[`PAR_BIT];
  // (R4) (R12) Sticky flags, set beats clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_reg <= `FLAG_RST;
    end else begin
      flags_reg.overrun <= set_ovr || (flags_reg.overrun && !clr_ovr);
      flags_reg.parity  <= set_par || (flags_reg.parity && !clr_par);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler wait after peripheral enable
  // Next wait count: restart when unpowered, hold at the limit
  wire [2:0] wait_cnt_next = !i_periph_enable ? 3'h0
                           : (wait_cnt_reg != `PRE_WAIT) ? wait_cnt_reg + 3'h1
                           : wait_cnt_reg;
  // (R10) Count four clocks before prescaler is writable
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_cnt_reg     <= 3'h0;
      prescaler_ok_reg <= 1'b0;
    end else begin
      wait_cnt_reg     <= wait_cnt_next;
      prescaler_ok_reg <= (wait_cnt_next == `PRE_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign o_data          = data_reg;
  assign o_buffer_full   = full_reg;
  assign o_status        = flags_reg;
  assign o_enable_status = en_reg;
  assign o_prescaler_ok  = prescaler_ok_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence stop_req_s;
    i_stop_trigger;
  endsequence
  buf_read_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R1)
    (i_buf_read && !byte_done) |=> !o_buffer_full)
    else $error("buffer full not cleared by read");
  clear_only_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R4)
    (i_clear_write && !i_clear_value[`OVR_BIT] && o_status[`OVR_BIT]) |=> o_status[`OVR_BIT])
    else $error("overrun cleared by zero bit");
  clear_one_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R4)
    (clr_par && !set_par) |=> !o_status[`PAR_BIT])
    else $error("parity not cleared");
  nack_flag_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R5)
    set_par |=> o_status[`PAR_BIT])
    else $error("missing acknowledge not flagged");
  overrun_flag_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R5)
    set_ovr |=> o_status[`OVR_BIT] && o_buffer_full && $stable(o_data))
    else $error("overrun not flagged or data overwritten");
  stop_halt_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R6)
    stop_req_s |=> !o_enable_status ##1 (state_reg == i2c_err_pkg::ST_IDLE))
    else $error("stop trigger did not halt");
  start_run_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R7)
    (i_start_trigger && !i_stop_trigger && chan_legal) |=> o_enable_status)
    else $error("start trigger did not enable");
  pair_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R11)
    !chan_legal |=> $stable(o_data))
    else $error("illegal pair received data");
  sticky_flag_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R12)
    (o_status[`PAR_BIT] && !clr_par) |=> o_status[`PAR_BIT])
    else $error("parity flag dropped without clear");
  presc_wait_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // (R10)
    $rose(i_periph_enable) |-> !o_prescaler_ok [*4] ##1 (o_prescaler_ok || !i_periph_enable))
    else $error("prescaler wait not four clocks");
endmodule
`default_nettype wire

// file: verilog/i2c_err_defs.svh
// Constants for the simplified I2C error recovery block
`ifndef I2C_ERR_DEFS_SVH
`define I2C_ERR_DEFS_SVH
// Status and clear bit positions
`define OVR_BIT   0
`define PAR_BIT   1
// Reset values
`define DATA_RST  8'h00
`define FLAG_RST  2'h0
// Supported unit/channel pairs, as {unit,channel}
`define PAIR_02   3'h2
`define PAIR_03   3'h3
`define PAIR_10   3'h4
`define PAIR_11   3'h5
// Wait after peripheral enable before prescaler writes, in clocks
`define PRE_WAIT  3'h4
// Index of the last data bit in one frame (address or data byte)
`define BIT_LAST  3'h7
`endif

// file: verilog/i2c_err_pkg.sv
// Types for the simplified I2C error recovery block
package i2c_err_pkg;
  // Error flags as seen in the channel status register
  typedef struct packed {
    logic parity;   // Slave gave no acknowledge
    logic overrun;  // Byte lost, buffer still full
  } err_flags_t;
  // Bit engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_ACK  = 2'b10
  } bit_state_t;
endpackage

// file: test/i2c_slave_model.sv
// Behavioural slave that clocks frames onto the bus lines
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
  output logic o_scl,  // Bus clock, pulled high outside frames
  output logic o_sda   // Bus data, pulled high when released
);
  // Lines rest at their pull-up level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Byte MSB first, then the acknowledge bit; data moves while the clock is low
  task automatic send_frame(input logic [7:0] data, input logic nack);
    logic [8:0] bits;  // Whole frame, acknowledge last
    bits = {data, nack};
    #2;
    for (int i = 8; i >= 0; i--) begin
      o_scl = 1'b0;
      #16 o_sda = bits[i];
      #16 o_scl = 1'b1;
      #32;
    end
    // Release data while the clock is high, as a stop condition
    o_sda = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the simplified I2C error recovery channel
`timescale 1ns/1ns
`default_nettype none
`include "i2c_err_defs.svh"
module tb;
  logic       i_clock;          // Bench clock
  logic       i_nrst;           // Reset, active low
  logic [2:0] i_pair;           // Unit and channel
  logic       i_buf_read;       // Buffer read pulse
  logic       i_clear_write;    // Flag clear pulse
  logic [1:0] i_clear_value;    // Flag clear value
  logic       i_stop_trigger;   // Stop pulse
  logic       i_start_trigger;  // Start pulse
  logic       i_periph_enable;  // Peripheral enable
  logic       scl_line;         // Bus clock from slave
  logic       sda_line;         // Bus data from slave
  logic [7:0] o_data;           // Receive buffer
  logic       o_buffer_full;    // Buffer full flag
  logic [1:0] o_status;         // Error flags
  logic       o_enable_status;  // Channel enable
  logic       o_prescaler_ok;   // Prescaler writable
  int         n_mismatch;       // Failed compares
  int         comparisons;      // All compares
  logic       legal;            // Expected pair legality
  simple_i2c_error_recovery uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_pair(i_pair),
    .i_buf_read(i_buf_read), .i_clear_write(i_clear_write), .i_clear_value(i_clear_value),
    .i_stop_trigger(i_stop_trigger), .i_start_trigger(i_start_trigger),
    .i_periph_enable(i_periph_enable), .i_scl(scl_line), .i_sda(sda_line),
    .o_data(o_data), .o_buffer_full(o_buffer_full), .o_status(o_status),
    .o_enable_status(o_enable_status), .o_prescaler_ok(o_prescaler_ok));
  i2c_slave_model partner (.o_scl(scl_line), .o_sda(sda_line));
  // Clock, 8 ns period
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Step n edges, then drive just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Compares one result
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  // One-cycle pulse of {read, clear, stop, start}
  task automatic pulse(input logic [3:0] sel);
    {i_buf_read, i_clear_write, i_stop_trigger, i_start_trigger} = sel;
    cyc(1);
    {i_buf_read, i_clear_write, i_stop_trigger, i_start_trigger} = 4'h0;
    cyc(1);
  endtask
  // One bus frame, then time for the synchroniser
  task automatic frame(input logic [7:0] d, input logic nack);
    partner.send_frame(d, nack);
    cyc(6);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    {i_nrst, i_buf_read, i_clear_write, i_stop_trigger, i_start_trigger} = 5'h00;
    {i_periph_enable, i_clear_value, i_pair} = {1'b0, 2'h0, 3'h0};
    n_mismatch = 0;
    comparisons = 0;
    cyc(3);
    i_nrst = 1'b1;
    chk("st", 8'h00, {6'h00, o_status});
    chk("full", 8'h00, {7'h00, o_buffer_full});
    i_periph_enable = 1'b1;
    cyc(2);
    chk("pre", 8'h00, {7'h00, o_prescaler_ok});
    cyc(4);
    chk("pre", 8'h01, {7'h00, o_prescaler_ok});
    for (int p = 0; p < 8; p++) begin
      i_pair = 3'(p);
      legal = i_pair == `PAIR_02 || i_pair == `PAIR_03 || i_pair == `PAIR_10;
      legal = legal || i_pair == `PAIR_11;
      pulse(4'h1);
      chk("en", {7'h00, legal}, {7'h00, o_enable_status});
      pulse(4'h2);
      chk("en", 8'h00, {7'h00, o_enable_status});
    end
    i_pair = `PAIR_10;
    pulse(4'h1);
    chk("en", 8'h01, {7'h00, o_enable_status});
    frame(8'ha5, 1'b0);
    chk("data", 8'ha5, o_data);
    chk("st", 8'h00, {6'h00, o_status});
    frame(8'h3c, 1'b0);
    chk("st", 8'h01, {6'h00, o_status});
    chk("data", 8'ha5, o_data);
    pulse(4'h8);
    chk("full", 8'h00, {7'h00, o_buffer_full});
    frame(8'h5a, 1'b1);
    chk("full", 8'h01, {7'h00, o_buffer_full});
    chk("data", 8'h5a, o_data);
    chk("st", 8'h03, {6'h00, o_status});
    i_clear_value = 2'b01;
    pulse(4'h4);
    chk("st", 8'h02, {6'h00, o_status});
    frame(8'h11, 1'b0);
    chk("st", 8'h03, {6'h00, o_status});
    i_clear_value = 2'b10;
    pulse(4'h4);
    chk("st", 8'h01, {6'h00, o_status});
    pulse(4'h8);
    i_clear_value = 2'b11;
    pulse(4'h4);
    chk("st", 8'h00, {6'h00, o_status});
    pulse(4'h2);
    chk("en", 8'h00, {7'h00, o_enable_status});
    frame(8'hff, 1'b1);
    chk("full", 8'h00, {7'h00, o_buffer_full});
    chk("st", 8'h00, {6'h00, o_status});
    pulse(4'h1);
    chk("en", 8'h01, {7'h00, o_enable_status});
    frame(8'hc3, 1'b0);
    chk("data", 8'hc3, o_data);
    finish_test();
  end
endmodule
`default_nettype wire
